// file: design/fprt_pkg.sv
package fprt_pkg;

   // Instruction class recognition
   localparam logic [3:0] CLASS_CODE = 4'he;
   localparam logic [3:0] CPNUM_CODE = 4'h1;
   localparam logic [3:0] PC_REG     = 4'hf;

   // Opcodes formed from {abc, direction}
   localparam logic [3:0] OP_INT_TO_FLOAT = 4'h0;
   localparam logic [3:0] OP_FLOAT_TO_INT = 4'h1;
   localparam logic [3:0] OP_WR_STATUS    = 4'h2;
   localparam logic [3:0] OP_RD_STATUS    = 4'h3;
   localparam logic [3:0] OP_WR_CONTROL   = 4'h4;
   localparam logic [3:0] OP_RD_CONTROL   = 4'h5;
   localparam logic [2:0] ABC_UNDEF_PAIR  = 3'h3;

   // Compare subcode bits within abc
   localparam int CMP_CLASS_BIT = 2;
   localparam int CMP_EXC_BIT   = 1;
   localparam int CMP_NEG_BIT   = 0;

   // Precision and rounding encodings
   localparam logic [1:0] PREC_SINGLE   = 2'h0;
   localparam logic [1:0] PREC_DOUBLE   = 2'h1;
   localparam logic [1:0] PREC_EXTENDED = 2'h2;
   localparam logic [1:0] PREC_BAD      = 2'h3;
   localparam logic [1:0] RND_NEAREST   = 2'h0;
   localparam logic [1:0] RND_PLUS      = 2'h1;
   localparam logic [1:0] RND_MINUS     = 2'h2;
   localparam logic [1:0] RND_ZERO      = 2'h3;

   // Status and control register layout
   localparam int          STAT_INVALID_BIT   = 0;
   localparam int          STAT_ALT_FLAGS_BIT = 12;
   localparam logic [31:0] STATUS_RESET       = 32'h0;
   localparam logic [31:0] CONTROL_RESET      = 32'h0;

   // Single precision format
   localparam logic [7:0]  EXP_BIAS     = 8'h7f;
   localparam logic [7:0]  EXP_MAX      = 8'hff;
   localparam logic [7:0]  EXP_INT_LIM  = 8'h9e;
   localparam logic [7:0]  EXP_FIX_BASE = 8'h76;
   localparam logic [31:0] INT_MAX_POS  = 32'h7fffffff;
   localparam logic [31:0] INT_MAX_NEG  = 32'h80000000;

   // Built-in constants: 0.0 1.0 2.0 3.0 4.0 5.0 0.5 10.0
   localparam logic [31:0] CONST_TABLE [8] = '{32'h00000000, 32'h3f800000, 32'h40000000, 32'h40400000,
                                              32'h40800000, 32'h40a00000, 32'h3f000000, 32'h41200000};

   typedef struct packed {
      logic [3:0] cond;
      logic [3:0] cls;
      logic [2:0] abc;
      logic       dir;
      logic       precHi;
      logic [2:0] fpDest;
      logic [3:0] rd;
      logic [3:0] cpNum;
      logic       precLo;
      logic [1:0] rnd;
      logic       one;
      logic       constSel;
      logic [2:0] fpSource;
   } fprt_instr_t;

   typedef struct packed {
      logic n;
      logic z;
      logic c;
      logic v;
   } fprt_flags_t;

endpackage

// file: design/fprt_regfile.sv
`timescale 1ns/1ps
module fprt_regfile
(
   // Clock
   input  wire logic        clk,
   // Read ports, data registered
   input  wire logic [2:0]  rdAddrA,
   input  wire logic [2:0]  rdAddrB,
   output logic      [31:0] rdDataA,
   output logic      [31:0] rdDataB,
   // Write ports, port B wins on the same address
   input  wire logic        wrEnA,
   input  wire logic [2:0]  wrAddrA,
   input  wire logic [31:0] wrDataA,
   input  wire logic        wrEnB,
   input  wire logic [2:0]  wrAddrB,
   input  wire logic [31:0] wrDataB
);

   logic [31:0] mem [8];

   always_ff @(posedge clk)
   begin
      if (wrEnA)
         mem[wrAddrA] <= wrDataA;
      if (wrEnB)
         mem[wrAddrB] <= wrDataB;
   end

   always_ff @(posedge clk)
   begin
      rdDataA <= mem[rdAddrA];
      rdDataB <= mem[rdAddrB];
   end

endmodule

// file: design/fprt_decode.sv
`timescale 1ns/1ps
// Operation
// - Direction one sends to host register, zero takes from host register.
// - Opcode 0000 converts host integer to float into destination register.
// - Opcode 0100 writes host value into the control register.
// - Opcode 0101 returns control register contents to the host.
// - Control register transfers are supervisor-only.
// - Opcodes 011x and 1xx0 raise the undefined-instruction trap.
// - For conversion, ef gives precision and gh gives rounding mode.
// - Compare is a transfer with host register 15, direction one; sets flags.
// - Subcodes 100 plain, 101 negated, 110/111 same with unordered exception.
// - Exception compare signals invalid operation on any NaN.
// - Plain compare signals only on signalling NaN; quiet NaN gives unordered.
// - Normal flags: N less, Z equal, C greater-or-equal, V unordered.
// - Alternative flags also set C when unordered, so N and C complement.
// - Rounding: 00 nearest, 01 plus, 10 minus, 11 zero.
// - Precision 00 single, 01 double, 10 extended; 11 traps undefined. Code gives a single result for all three, and traps 11 on opcode 0000 only.
// - Constant select picks 0,1,2,3,4,5,0.5,10 for codes 000 to 111.
module fprt_decode
(
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         rst,
   // Instruction issue
   input  wire logic         issueValid,
   input  wire logic [31:0]  issueInstr,
   input  wire logic [31:0]  issueRdValue,
   input  wire logic         supervisorMode,
   output logic              issueReady,
   // Register preload path
   input  wire logic         loadEn,
   input  wire logic [2:0]   loadAddr,
   input  wire logic [31:0]  loadData,
   // Results
   output logic              doneValid,
   output logic              hostWrite,
   output logic [31:0]       hostData,
   output logic              flagsWrite,
   output fprt_pkg::fprt_flags_t flags,
   output logic              undefTrap,
   output logic              invalidExc,
   output logic [31:0]       statusValue
);

   typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_EXEC} fprt_state_t;

   fprt_state_t           state_reg;
   fprt_pkg::fprt_instr_t instr_reg;
   fprt_pkg::fprt_instr_t issueFields;
   logic [31:0]           rdValue_reg;
   logic                  super_reg;
   logic [31:0]           control_reg;
   logic [31:0]           opA;
   logic [31:0]           opB;
   logic [31:0]           rfA;
   logic [31:0]           rfB;
   logic [31:0]           cvtValue;
   logic [32:0]           fixValue;
   logic [3:0]            opcode;
   logic                  isXfer;
   logic                  accept;
   logic                  execNow;
   logic                  cvtWrite;
   logic                  undefNext;
   logic                  unord;
   logic                  anySnan;
   logic                  cmpInvalid;
   logic                  altFlags;

   function automatic logic roundUp(input logic lsb, input logic half, input logic sticky,
                                    input logic sign, input logic [1:0] rm);
      logic r;
      r = 1'b0;
      case (rm)
         fprt_pkg::RND_NEAREST: r = half & (sticky | lsb);
         fprt_pkg::RND_PLUS:    r = (half | sticky) & ~sign;
         fprt_pkg::RND_MINUS:   r = (half | sticky) & sign;
         default:               r = 1'b0;
      endcase
      return r;
   endfunction

   function automatic logic [31:0] intToFloat(input logic [31:0] v, input logic [1:0] rm);
      logic        sign;
      logic [31:0] mag;
      logic [4:0]  msb;
      logic [63:0] norm;
      logic [24:0] man;
      logic [7:0]  ex;
      sign = v[31];
      mag  = sign ? 32'(-v) : v;
      msb  = 5'h0;
      for (int i = 0; i < 32; i++)
         if (mag[i])
            msb = 5'(i);
      norm = {mag, 32'h0} << (5'h1f - msb);
      man  = {1'b0, norm[63:40]} + {24'h0, roundUp(norm[40], norm[39], |norm[38:0], sign, rm)};
      ex   = fprt_pkg::EXP_BIAS + {3'h0, msb} + {7'h0, man[24]};
      if (mag == 32'h0)
         return 32'h0;
      return {sign, ex, man[24] ? 23'h0 : man[22:0]};
   endfunction

   // Returns {invalid, value}; out-of-range saturates, NaN gives zero, and both flag invalid
   function automatic logic [32:0] floatToInt(input logic [31:0] f, input logic [1:0] rm);
      logic [7:0]  ex;
      logic [63:0] fx;
      logic [31:0] mag;
      logic        sign;
      sign = f[31];
      ex   = f[30:23];
      fx   = 64'h1;
      if (ex == fprt_pkg::EXP_MAX && f[22:0] != 23'h0)
         return {1'b1, 32'h0};
      if (ex == fprt_pkg::EXP_INT_LIM && sign && f[22:0] == 23'h0)
         return {1'b0, fprt_pkg::INT_MAX_NEG};
      if (ex >= fprt_pkg::EXP_INT_LIM)
         return {1'b1, sign ? fprt_pkg::INT_MAX_NEG : fprt_pkg::INT_MAX_POS};
      if (ex == 8'h0)
         return {1'b0, 32'h0};
      if (ex >= fprt_pkg::EXP_FIX_BASE)
         fx = {40'h0, 1'b1, f[22:0]} << (ex - fprt_pkg::EXP_FIX_BASE);
      mag = fx[63:32] + {31'h0, roundUp(fx[32], fx[31], |fx[30:0], sign, rm)};
      if (!sign && mag[31])
         return {1'b1, fprt_pkg::INT_MAX_POS};
      return {1'b0, sign ? 32'(-mag) : mag};
   endfunction

   function automatic logic isNan(input logic [31:0] f);
      return f[30:23] == fprt_pkg::EXP_MAX && f[22:0] != 23'h0;
   endfunction

   function automatic logic bothZero(input logic [31:0] a, input logic [31:0] b);
      return a[30:0] == 31'h0 && b[30:0] == 31'h0;
   endfunction

   function automatic logic lessThan(input logic [31:0] a, input logic [31:0] b);
      if (bothZero(a, b))
         return 1'b0;
      if (a[31] != b[31])
         return a[31];
      return a[31] ? (a[30:0] > b[30:0]) : (a[30:0] < b[30:0]);
   endfunction

   assign issueFields = issueInstr;
   assign isXfer      = issueFields.cls == fprt_pkg::CLASS_CODE && issueFields.cpNum == fprt_pkg::CPNUM_CODE
                        && issueFields.one;
   assign accept      = issueValid && issueReady && isXfer;
   assign execNow     = state_reg == ST_EXEC;
   assign opcode      = {instr_reg.abc, instr_reg.dir};
   assign altFlags    = statusValue[fprt_pkg::STAT_ALT_FLAGS_BIT];

   fprt_regfile regs
   (
      .clk     (clk),
      .rdAddrA (instr_reg.fpDest),
      .rdAddrB (instr_reg.fpSource),
      .rdDataA (rfA),
      .rdDataB (rfB),
      .wrEnA   (loadEn),
      .wrAddrA (loadAddr),
      .wrDataA (loadData),
      .wrEnB   (cvtWrite),
      .wrAddrB (instr_reg.fpDest),
      .wrDataB (cvtValue)
   );

   // Operand selection and conversions
   always_comb
   begin
      opA = rfA;
      opB = instr_reg.constSel ? fprt_pkg::CONST_TABLE[instr_reg.fpSource] : rfB;
      if (instr_reg.abc[fprt_pkg::CMP_NEG_BIT])
         opB[31] = ~opB[31];
      cvtValue = intToFloat(rdValue_reg, instr_reg.rnd);
      fixValue = floatToInt(opB, instr_reg.rnd);
      unord    = isNan(opA) || isNan(opB);
      anySnan  = (isNan(opA) && !opA[22]) || (isNan(opB) && !opB[22]);
      cmpInvalid = instr_reg.abc[fprt_pkg::CMP_EXC_BIT] ? unord : anySnan;
   end

   // Decode of the latched instruction into the trap decision
   always_comb
   begin
      undefNext = 1'b0;
      cvtWrite  = 1'b0;
      if (instr_reg.abc[fprt_pkg::CMP_CLASS_BIT])
         undefNext = !instr_reg.dir || instr_reg.rd != fprt_pkg::PC_REG;
      else if (instr_reg.abc == fprt_pkg::ABC_UNDEF_PAIR)
         undefNext = 1'b1;
      else if (opcode == fprt_pkg::OP_WR_CONTROL || opcode == fprt_pkg::OP_RD_CONTROL)
         undefNext = !super_reg;
      else if (opcode == fprt_pkg::OP_INT_TO_FLOAT)
         undefNext = {instr_reg.precHi, instr_reg.precLo} == fprt_pkg::PREC_BAD;
      cvtWrite = execNow && !undefNext && opcode == fprt_pkg::OP_INT_TO_FLOAT;
   end

   // Sequencer: one instruction in flight, register file read takes one cycle
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         state_reg <= ST_IDLE;
      else
         case (state_reg)
            ST_IDLE: state_reg <= accept ? ST_READ : ST_IDLE;
            ST_READ: state_reg <= ST_EXEC;
            ST_EXEC: state_reg <= ST_IDLE;
            default: state_reg <= ST_IDLE;
         endcase
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         issueReady <= 1'b0;
      else
         issueReady <= accept ? 1'b0 : (state_reg == ST_IDLE || execNow);
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         instr_reg   <= '0;
         rdValue_reg <= 32'h0;
         super_reg   <= 1'b0;
      end
      else if (accept)
      begin
         instr_reg   <= issueFields;
         rdValue_reg <= issueRdValue;
         super_reg   <= supervisorMode;
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         control_reg <= fprt_pkg::CONTROL_RESET;
      else if (execNow && !undefNext && opcode == fprt_pkg::OP_WR_CONTROL)
         control_reg <= rdValue_reg;
   end

   // Sticky invalid bit: a new exception wins over a status write
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         statusValue <= fprt_pkg::STATUS_RESET;
      else if (execNow && !undefNext)
      begin
         if (opcode == fprt_pkg::OP_WR_STATUS)
            statusValue <= rdValue_reg;
         if (instr_reg.abc[fprt_pkg::CMP_CLASS_BIT] && cmpInvalid)
            statusValue[fprt_pkg::STAT_INVALID_BIT] <= 1'b1;
         else if (opcode == fprt_pkg::OP_FLOAT_TO_INT && fixValue[32])
            statusValue[fprt_pkg::STAT_INVALID_BIT] <= 1'b1;
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         doneValid  <= 1'b0;
         undefTrap  <= 1'b0;
         hostWrite  <= 1'b0;
         hostData   <= 32'h0;
         flagsWrite <= 1'b0;
         flags      <= '0;
         invalidExc <= 1'b0;
      end
      else
      begin
         doneValid  <= execNow;
         undefTrap  <= execNow && undefNext;
         hostWrite  <= 1'b0;
         flagsWrite <= 1'b0;
         invalidExc <= 1'b0;
         if (execNow && !undefNext)
         begin
            if (instr_reg.abc[fprt_pkg::CMP_CLASS_BIT])
            begin
               flagsWrite <= 1'b1;
               flags.n    <= !unord && lessThan(opA, opB);
               flags.z    <= !unord && (opA == opB || bothZero(opA, opB));
               flags.c    <= unord ? altFlags : !lessThan(opA, opB);
               flags.v    <= unord;
               invalidExc <= cmpInvalid;
            end
            else if (instr_reg.dir)
            begin
               hostWrite <= 1'b1;
               case (opcode)
                  fprt_pkg::OP_FLOAT_TO_INT: hostData <= fixValue[31:0];
                  fprt_pkg::OP_RD_STATUS:    hostData <= statusValue;
                  fprt_pkg::OP_RD_CONTROL:   hostData <= control_reg;
                  default:                   hostData <= 32'h0;
               endcase
               invalidExc <= opcode == fprt_pkg::OP_FLOAT_TO_INT && fixValue[32];
            end
         end
      end
   end

   sequence sTrapOnly;
      undefTrap && doneValid && !hostWrite && !flagsWrite;
   endsequence

   sequence sHostAnswer;
      doneValid && hostWrite && !undefTrap;
   endsequence

   a_accept_answers: assert property (@(posedge clk) disable iff (rst) accept |-> ##3 doneValid)
      else $error("accepted instruction not answered in three cycles");
   a_foreign_ignored: assert property (@(posedge clk) disable iff (rst)
      issueValid && issueReady && !isXfer |=> issueReady && state_reg == ST_IDLE)
      else $error("foreign instruction was taken");
   a_undef_opcode: assert property (@(posedge clk) disable iff (rst)
      accept && issueFields.abc == fprt_pkg::ABC_UNDEF_PAIR |-> ##3 sTrapOnly)
      else $error("undefined opcode did not trap");
   a_priv_control: assert property (@(posedge clk) disable iff (rst)
      accept && !supervisorMode && issueFields.abc == fprt_pkg::OP_WR_CONTROL[3:1] |-> ##3 sTrapOnly)
      else $error("user-mode control transfer not trapped");
   a_rd_control: assert property (@(posedge clk) disable iff (rst)
      accept && supervisorMode && {issueFields.abc, issueFields.dir} == fprt_pkg::OP_RD_CONTROL
      |-> ##3 sHostAnswer ##0 hostData == control_reg)
      else $error("control read returned wrong value");
   a_wr_control: assert property (@(posedge clk) disable iff (rst)
      accept && supervisorMode && {issueFields.abc, issueFields.dir} == fprt_pkg::OP_WR_CONTROL
      |-> ##3 control_reg == $past(issueRdValue, 3))
      else $error("control write not stored");
   a_prec_trap: assert property (@(posedge clk) disable iff (rst)
      accept && {issueFields.abc, issueFields.dir} == fprt_pkg::OP_INT_TO_FLOAT
      && {issueFields.precHi, issueFields.precLo} == fprt_pkg::PREC_BAD |-> ##3 sTrapOnly)
      else $error("bad precision did not trap");
   a_host_direction: assert property (@(posedge clk) disable iff (rst) hostWrite |-> instr_reg.dir)
      else $error("host write with direction zero");
   a_unord_flags: assert property (@(posedge clk) disable iff (rst)
      flagsWrite && flags.v |-> !flags.n && !flags.z && flags.c == altFlags)
      else $error("unordered flag pattern wrong");
   a_order_flags: assert property (@(posedge clk) disable iff (rst)
      flagsWrite && !flags.v |-> flags.n != flags.c)
      else $error("ordered compare N and C not complementary");
   a_exc_compare: assert property (@(posedge clk) disable iff (rst)
      flagsWrite && flags.v && instr_reg.abc[fprt_pkg::CMP_EXC_BIT] |-> invalidExc)
      else $error("exception compare missed invalid on NaN");

endmodule

// file: verif/fprt_host_model.sv
`timescale 1ns/1ps
module fprt_host_model
(
   // Clock
   input  wire logic        clk,
   // Issue side
   output logic             issueValid,
   output logic [31:0]      issueInstr,
   output logic [31:0]      issueRdValue,
   output logic             supervisorMode,
   input  wire logic        issueReady,
   // Completion
   input  wire logic        doneValid
);
   initial
   begin
      issueValid = 1'b0;
      issueInstr = 32'h0;
      issueRdValue = 32'h0;
      supervisorMode = 1'b0;
   end

   // Holds the word until issueReady is seen, then waits a bounded time for completion
   task automatic send(input fprt_pkg::fprt_instr_t w, input logic [31:0] v, input logic s, output logic ok);
      logic [3:0] op;
      int         n;
      op = {w.abc, w.dir};
      if (op != fprt_pkg::OP_INT_TO_FLOAT)
      begin
         w.precHi = 1'b0;
         w.precLo = 1'b0;
      end
      if (op != fprt_pkg::OP_INT_TO_FLOAT && op != fprt_pkg::OP_FLOAT_TO_INT)
         w.rnd = 2'h0;
      if (op == fprt_pkg::OP_FLOAT_TO_INT)
         w.constSel = 1'b0;
      issueInstr = w;
      issueRdValue = v;
      supervisorMode = s;
      issueValid = 1'b1;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (issueReady !== 1'b1 && n < 16);
      #1;
      issueValid = 1'b0;
      // Released lines must not look like a still-valid word
      issueInstr = ~w;
      issueRdValue = ~v;
      n = 0;
      while (doneValid !== 1'b1 && n < 16)
      begin
         @(posedge clk);
         #1;
         n++;
      end
      ok = (doneValid === 1'b1);
   endtask
endmodule

// file: verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   logic                  clk;
   logic                  rst;
   logic                  issueValid;
   logic [31:0]           issueInstr;
   logic [31:0]           issueRdValue;
   logic                  supervisorMode;
   logic                  issueReady;
   logic                  loadEn;
   logic [2:0]            loadAddr;
   logic [31:0]           loadData;
   logic                  doneValid;
   logic                  hostWrite;
   logic [31:0]           hostData;
   logic                  flagsWrite;
   fprt_pkg::fprt_flags_t flags;
   logic                  undefTrap;
   logic                  invalidExc;
   logic [31:0]           statusValue;
   int                    badCount = 0;
   int                    checks = 0;
   int                    cycles = 0;

   fprt_decode dut_u (.clk(clk), .rst(rst), .issueValid(issueValid), .issueInstr(issueInstr),
      .issueRdValue(issueRdValue), .supervisorMode(supervisorMode), .issueReady(issueReady),
      .loadEn(loadEn), .loadAddr(loadAddr), .loadData(loadData), .doneValid(doneValid),
      .hostWrite(hostWrite), .hostData(hostData), .flagsWrite(flagsWrite), .flags(flags),
      .undefTrap(undefTrap), .invalidExc(invalidExc), .statusValue(statusValue));

   fprt_host_model host_u (.clk(clk), .issueValid(issueValid), .issueInstr(issueInstr),
      .issueRdValue(issueRdValue), .supervisorMode(supervisorMode), .issueReady(issueReady),
      .doneValid(doneValid));

   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   task automatic stop_test();
      $display("checks %0d errors %0d", checks, badCount);
      if (badCount == 0 && checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         badCount++;
         $display("[ERR] %0t run did not finish", $time);
         stop_test();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         badCount++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic load(input logic [2:0] a, input logic [31:0] d);
      loadEn = 1'b1;
      loadAddr = a;
      loadData = d;
      @(posedge clk);
      #1;
      loadEn = 1'b0;
      @(posedge clk);
      #1;
   endtask

   task automatic run(input logic [3:0] op, input logic [2:0] dst, input logic [3:0] r, input logic [3:0] efgh,
                      input logic [3:0] src, input logic [31:0] v, input logic s);
      fprt_pkg::fprt_instr_t w;
      logic                  ok;
      w = '{cond: 4'he, cls: fprt_pkg::CLASS_CODE, abc: op[3:1], dir: op[0], precHi: efgh[3], fpDest: dst,
            rd: r, cpNum: fprt_pkg::CPNUM_CODE, precLo: efgh[2], rnd: efgh[1:0], one: 1'b1,
            constSel: src[3], fpSource: src[2:0]};
      host_u.send(w, v, s, ok);
      chk({31'h0, ok}, 32'h1);
   endtask

   task automatic cmp(input logic [2:0] abc, input logic [2:0] dst, input logic [3:0] src,
                      input logic [3:0] f, input logic e);
      run({abc, 1'b1}, dst, 4'hf, 4'h0, src, 32'h0, 1'b0);
      chk({26'h0, undefTrap, flagsWrite, flags}, {26'h0, 2'h1, f});
      chk({31'h0, invalidExc}, {31'h0, e});
   endtask

   task automatic t_ctrl();
      run(fprt_pkg::OP_WR_CONTROL, 3'h0, 4'h3, 4'h0, 4'h0, 32'h1234abcd, 1'b1);
      chk({30'h0, hostWrite, undefTrap}, 32'h0);
      run(fprt_pkg::OP_RD_CONTROL, 3'h0, 4'h3, 4'h0, 4'h0, 32'h0, 1'b1);
      chk({hostWrite, undefTrap, hostData[29:0]}, {2'h2, 30'h1234abcd});
      run(fprt_pkg::OP_WR_CONTROL, 3'h0, 4'h3, 4'h0, 4'h0, 32'h0, 1'b0);
      chk({30'h0, hostWrite, undefTrap}, 32'h1);
      run(fprt_pkg::OP_RD_CONTROL, 3'h0, 4'h3, 4'h0, 4'h0, 32'h0, 1'b0);
      chk({30'h0, hostWrite, undefTrap}, 32'h1);
      run(fprt_pkg::OP_RD_CONTROL, 3'h0, 4'h3, 4'h0, 4'h0, 32'h0, 1'b1);
      chk(hostData, 32'h1234abcd);
   endtask

   task automatic t_undef();
      logic [3:0] ops [6] = '{4'h6, 4'h7, 4'h8, 4'ha, 4'hc, 4'he};
      foreach (ops[k])
      begin
         run(ops[k], 3'h0, 4'h0, 4'h0, 4'h0, 32'h0, 1'b1);
         chk({29'h0, undefTrap, hostWrite, flagsWrite}, 32'h4);
      end
      run(4'h9, 3'h0, 4'h3, 4'h0, 4'h1, 32'h0, 1'b0);
      chk({29'h0, undefTrap, hostWrite, flagsWrite}, 32'h4);
   endtask

   // A word for another coprocessor must be left alone: no take, no answer
   task automatic t_foreign();
      fprt_pkg::fprt_instr_t w;
      logic                  ok;
      w = '{cond: 4'he, cls: fprt_pkg::CLASS_CODE, abc: 3'h2, dir: 1'b1, precHi: 1'b0, fpDest: 3'h0, rd: 4'h3,
            cpNum: 4'h2, precLo: 1'b0, rnd: 2'h0, one: 1'b1, constSel: 1'b0, fpSource: 3'h0};
      host_u.send(w, 32'h0, 1'b1, ok);
      chk({31'h0, ok}, 32'h0);
   endtask

   task automatic t_conv();
      logic [31:0] cst [8] = '{32'h00000000, 32'h3f800000, 32'h40000000, 32'h40400000,
                               32'h40800000, 32'h40a00000, 32'h3f000000, 32'h41200000};
      logic [31:0] up [4] = '{32'h2, 32'h3, 32'h2, 32'h2};
      logic [31:0] dn [4] = '{32'hfffffffe, 32'hffffffff, 32'hfffffffe, 32'hffffffff};
      for (int p = 0; p < 3; p++)
      begin
         run(fprt_pkg::OP_INT_TO_FLOAT, 3'h7, 4'h0, {p[1:0], 2'h0}, 4'h0, p + 1, 1'b0);
         cmp(3'h4, 3'h7, {1'b1, p[2:0] + 3'h1}, 4'h6, 1'b0);
      end
      run(fprt_pkg::OP_INT_TO_FLOAT, 3'h7, 4'h0, 4'hc, 4'h0, 32'h5, 1'b0);
      chk({31'h0, undefTrap}, 32'h1);
      cmp(3'h4, 3'h7, 4'hb, 4'h6, 1'b0);
      for (int k = 0; k < 8; k++)
      begin
         load(3'h7, cst[k]);
         cmp(3'h4, 3'h7, {1'b1, k[2:0]}, 4'h6, 1'b0);
      end
      load(3'h5, 32'h40200000);
      load(3'h6, 32'hbfc00000);
      for (int m = 0; m < 4; m++)
      begin
         run(fprt_pkg::OP_FLOAT_TO_INT, 3'h0, 4'h2, {2'h0, m[1:0]}, 4'h5, 32'h0, 1'b0);
         chk(hostData, up[m]);
         run(fprt_pkg::OP_FLOAT_TO_INT, 3'h0, 4'h2, {2'h0, m[1:0]}, 4'h6, 32'h0, 1'b0);
         chk({hostData[30:0], hostWrite}, {dn[m][30:0], 1'b1});
      end
   endtask

   task automatic t_cmp();
      load(3'h0, 32'h3f800000);
      load(3'h1, 32'h40000000);
      load(3'h2, 32'hbf800000);
      load(3'h3, 32'h7fc00000);
      load(3'h4, 32'h7f800001);
      cmp(3'h4, 3'h0, 4'h1, 4'h8, 1'b0);
      cmp(3'h4, 3'h1, 4'h0, 4'h2, 1'b0);
      cmp(3'h4, 3'h0, 4'h0, 4'h6, 1'b0);
      cmp(3'h5, 3'h0, 4'h2, 4'h6, 1'b0);
      cmp(3'h5, 3'h0, 4'h0, 4'h2, 1'b0);
      cmp(3'h4, 3'h0, 4'h3, 4'h1, 1'b0);
      cmp(3'h4, 3'h0, 4'h4, 4'h1, 1'b1);
      cmp(3'h6, 3'h3, 4'h0, 4'h1, 1'b1);
      cmp(3'h7, 3'h0, 4'h3, 4'h1, 1'b1);
      // NaN source to integer: zero result with invalid pulse
      run(fprt_pkg::OP_FLOAT_TO_INT, 3'h0, 4'h2, 4'h0, 4'h4, 32'h0, 1'b0);
      chk(hostData, 32'h0);
      chk({31'h0, invalidExc}, 32'h1);
      chk({31'h0, statusValue[0]}, 32'h1);
      run(fprt_pkg::OP_WR_STATUS, 3'h0, 4'h3, 4'h0, 4'h0, 32'h1000, 1'b0);
      chk(statusValue, 32'h1000);
      run(fprt_pkg::OP_RD_STATUS, 3'h0, 4'h3, 4'h0, 4'h0, 32'h0, 1'b0);
      chk(hostData, 32'h1000);
      cmp(3'h4, 3'h0, 4'h3, 4'h3, 1'b0);
      cmp(3'h4, 3'h0, 4'h1, 4'h8, 1'b0);
      cmp(3'h4, 3'h1, 4'h0, 4'h2, 1'b0);
   endtask

   initial
   begin
      rst = 1'b1;
      loadEn = 1'b0;
      loadAddr = 3'h0;
      loadData = 32'h0;
      repeat (16) @(posedge clk);
      #1;
      rst = 1'b0;
      repeat (2) @(posedge clk);
      #1;
      t_ctrl();
      t_foreign();
      t_undef();
      t_conv();
      t_cmp();
      stop_test();
   end
endmodule
